// ==== bstap_regs.svh ====
// Scan-port constants: widths, instruction codes, capture values
`ifndef BSTAP_REGS_SVH
`define BSTAP_REGS_SVH
`define BST_IR_W        5
`define BST_IR_CAPTURE  5'h01
`define BST_OP_EXTEST   5'h00
`define BST_OP_SAMPLE   5'h01
`define BST_OP_IDREAD   5'h02
`define BST_OP_FLOAT    5'h03
`define BST_BSR_LEN     281
`define BST_BSR_MSB     280
`define BST_RSVD_BIT    0
`define BST_ID_W        32
`define BST_KIND_RSVD   2'h0
`define BST_KIND_INPUT  2'h1
`define BST_KIND_DATA   2'h2
`define BST_KIND_ENABLE 2'h3
`endif

// ==== bstap_pkg.sv ====
// Scan-port types, instruction decode and boundary cell map
`default_nettype none
`include "bstap_regs.svh"
package bstap_pkg;

  typedef enum logic [3:0] {
    BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SHIFT_DR, BST_EXIT1_DR,
    BST_PAUSE_DR, BST_EXIT2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR,
    BST_SHIFT_IR, BST_EXIT1_IR, BST_PAUSE_IR, BST_EXIT2_IR, BST_UPD_IR
  } bstap_state_e;

  typedef struct packed {
    logic extest;
    logic sample;
    logic idcode;
    logic float_all_outputs_instr;
    logic bypass;
  } bstap_sel_s;

  typedef logic [1:0] bstap_kind_t;

  function automatic bstap_sel_s bstap_decode(input logic [`BST_IR_W-1:0] op);
    bstap_sel_s s;
    s = '0;
    case (op)
      `BST_OP_EXTEST: s.extest = 1'b1;
      `BST_OP_SAMPLE: s.sample = 1'b1;
      `BST_OP_IDREAD: s.idcode = 1'b1;
      `BST_OP_FLOAT:  s.float_all_outputs_instr  = 1'b1;
      default:        s.bypass = 1'b1;
    endcase
    return s;
  endfunction

  function automatic logic bstap_in(input int i, input int lo, input int hi);
    return (i >= lo) && (i <= hi);
  endfunction

  // Two-bit cells have enable above pin bit; parity of enable varies by run
  function automatic bstap_kind_t bstap_kind(input int i);
    logic ev;
    logic od;
    ev = bstap_in(i, 211, 280) || bstap_in(i, 165, 196) || bstap_in(i, 129, 138) ||
         bstap_in(i, 119, 122) || bstap_in(i, 109, 116) || bstap_in(i, 91, 102) ||
         bstap_in(i, 1, 78);
    od = bstap_in(i, 140, 163) || bstap_in(i, 124, 127) || bstap_in(i, 104, 107) ||
         bstap_in(i, 80, 89);
    if (i == `BST_RSVD_BIT)
      return `BST_KIND_RSVD;
    else if (ev)
      return (i % 2 == 0) ? `BST_KIND_ENABLE : `BST_KIND_DATA;
    else if (od)
      return (i % 2 == 1) ? `BST_KIND_ENABLE : `BST_KIND_DATA;
    else
      return `BST_KIND_INPUT;
  endfunction

endpackage
`default_nettype wire

// ==== bstap_top.sv ====
// Boundary-scan port: controller, instruction, boundary, id and bypass registers
`timescale 1ns/100ps
`default_nettype none
`include "bstap_regs.svh"
module bstap_top #(
  parameter logic [3:0]  ID_VERSION = 4'h0,     // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'hA5A5, // Arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h055   // Arbitrary value
) (
  // System clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       resetn_i,
  // Core side, system clock domain
  input  wire logic                       proc_reset_i,
  input  wire logic [`BST_BSR_MSB:0]      core_oe_i,
  output var  logic                       core_isolate_o,
  // Test port pins
  input  wire logic                       tck_i,
  input  wire logic                       trst_n_i,
  input  wire logic                       tms_i,
  input  wire logic                       tdi_i,
  output var  logic                       tdo_o,
  output var  logic                       tdo_oe_o,
  // Boundary pads, test clock domain
  input  wire logic [`BST_BSR_MSB:0]      pad_i,
  output var  logic [`BST_BSR_MSB:0]      bsc_out_o,
  output var  logic [`BST_BSR_MSB:0]      pad_oe_o,
  output var  bstap_pkg::bstap_sel_s      sel_o
);
  import bstap_pkg::*;

  logic                     tap_rst_n;
  bstap_state_e             state;
  bstap_state_e             next_state;
  logic [`BST_IR_W-1:0]     ir_sh;
  logic [`BST_IR_W-1:0]     next_ir_sh;
  logic [`BST_IR_W-1:0]     ir_out;
  logic [`BST_IR_W-1:0]     next_ir_out;
  bstap_sel_s               sel;
  bstap_sel_s               next_sel;
  logic                     iso_t;
  logic                     next_iso_t;
  logic [`BST_BSR_MSB:0]    bs_sh;
  logic [`BST_BSR_MSB:0]    next_bs_sh;
  logic [`BST_BSR_MSB:0]    bs_out;
  logic [`BST_BSR_MSB:0]    next_bs_out;
  logic [`BST_BSR_MSB:0]    next_pad_oe;
  logic [`BST_ID_W-1:0]     id_sh;
  logic [`BST_ID_W-1:0]     next_id_sh;
  logic                     byp;
  logic                     next_byp;
  logic                     next_tdo;
  logic                     next_tdo_oe;
  logic [`BST_BSR_MSB:0]    pad_s1;
  logic [`BST_BSR_MSB:0]    pad_s2;
  logic [`BST_BSR_MSB:0]    oe_s1;
  logic [`BST_BSR_MSB:0]    oe_s2;
  logic                     prst_m;
  logic                     prst_s1;
  logic                     prst_s2;
  logic                     iso_s1;
  logic                     bsr_path;

  // Either reset pin clears the test clock domain asynchronously
  assign tap_rst_n = trst_n_i & resetn_i;
  assign bsr_path  = sel.extest | sel.sample;

  // ****************************************
  // System clock domain
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prst_m         <= 1'b0;
      iso_s1         <= 1'b0;
      core_isolate_o <= 1'b0;
    end
    else
    begin
      prst_m         <= proc_reset_i;
      iso_s1         <= iso_t;
      core_isolate_o <= iso_s1;
    end
  end

  // ****************************************
  // Synchronisers into test clock
  // ****************************************
  always_ff @(posedge tck_i or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      pad_s1  <= '0;
      pad_s2  <= '0;
      oe_s1   <= '0;
      oe_s2   <= '0;
      prst_s1 <= 1'b0;
      prst_s2 <= 1'b0;
    end
    else
    begin
      pad_s1  <= pad_i;
      pad_s2  <= pad_s1;
      oe_s1   <= core_oe_i;
      oe_s2   <= oe_s1;
      prst_s1 <= prst_m;
      prst_s2 <= prst_s1;
    end
  end

  // ****************************************
  // Controller state
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      BST_RESET:    next_state = tms_i ? BST_RESET    : BST_IDLE;
      BST_IDLE:     next_state = tms_i ? BST_SEL_DR   : BST_IDLE;
      BST_SEL_DR:   next_state = tms_i ? BST_SEL_IR   : BST_CAP_DR;
      BST_CAP_DR:   next_state = tms_i ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_SHIFT_DR: next_state = tms_i ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_EXIT1_DR: next_state = tms_i ? BST_UPD_DR   : BST_PAUSE_DR;
      BST_PAUSE_DR: next_state = tms_i ? BST_EXIT2_DR : BST_PAUSE_DR;
      BST_EXIT2_DR: next_state = tms_i ? BST_UPD_DR   : BST_SHIFT_DR;
      BST_UPD_DR:   next_state = tms_i ? BST_SEL_DR   : BST_IDLE;
      BST_SEL_IR:   next_state = tms_i ? BST_RESET    : BST_CAP_IR;
      BST_CAP_IR:   next_state = tms_i ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_SHIFT_IR: next_state = tms_i ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_EXIT1_IR: next_state = tms_i ? BST_UPD_IR   : BST_PAUSE_IR;
      BST_PAUSE_IR: next_state = tms_i ? BST_EXIT2_IR : BST_PAUSE_IR;
      BST_EXIT2_IR: next_state = tms_i ? BST_UPD_IR   : BST_SHIFT_IR;
      BST_UPD_IR:   next_state = tms_i ? BST_SEL_DR   : BST_IDLE;
      default:      next_state = BST_RESET;
    endcase
    // Processor reset forces the controller home
    if (prst_s2)
      next_state = BST_RESET;
  end

  always_ff @(posedge tck_i or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      state <= BST_RESET;
    else
      state <= next_state;
  end

  // ****************************************
  // Instruction register
  // ****************************************
  always_comb
  begin
    next_ir_sh  = ir_sh;
    next_ir_out = ir_out;
    case (state)
      BST_RESET:    next_ir_out = `BST_OP_IDREAD;
      BST_CAP_IR:   next_ir_sh  = `BST_IR_CAPTURE;
      BST_SHIFT_IR: next_ir_sh  = {tdi_i, ir_sh[`BST_IR_W-1:1]};
      BST_UPD_IR:   next_ir_out = ir_sh;
      default:      next_ir_out = ir_out;
    endcase
    next_sel   = bstap_decode(next_ir_out);
    next_iso_t = next_sel.extest | next_sel.float_all_outputs_instr;
  end

  always_ff @(posedge tck_i or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      ir_sh  <= `BST_IR_CAPTURE;
      ir_out <= `BST_OP_IDREAD;
      sel    <= '{extest: 1'b0, sample: 1'b0, idcode: 1'b1, float_all_outputs_instr: 1'b0, bypass: 1'b0};
      iso_t  <= 1'b0;
    end
    else
    begin
      ir_sh  <= next_ir_sh;
      ir_out <= next_ir_out;
      sel    <= next_sel;
      iso_t  <= next_iso_t;
    end
  end

  assign sel_o = sel;

  // ****************************************
  // Boundary chain
  // ****************************************
  always_comb
  begin
    next_bs_sh  = bs_sh;
    next_bs_out = bs_out;
    next_pad_oe = '0;
    if (state == BST_CAP_DR && bsr_path)
    begin
      for (int i = 0; i < `BST_BSR_LEN; i++)
      begin
        case (bstap_kind(i))
          `BST_KIND_INPUT:  next_bs_sh[i] = pad_s2[i];
          `BST_KIND_DATA:   next_bs_sh[i] = pad_s2[i];
          `BST_KIND_ENABLE: next_bs_sh[i] = sel.sample ? oe_s2[i] : bs_sh[i];
          default:          next_bs_sh[i] = 1'b0;
        endcase
      end
    end
    if (state == BST_SHIFT_DR && bsr_path)
      next_bs_sh = {tdi_i, bs_sh[`BST_BSR_MSB:1]};
    if (state == BST_UPD_DR && bsr_path)
      next_bs_out = bs_sh;
    for (int i = 0; i < `BST_BSR_MSB; i++)
    begin
      if (bstap_kind(i) == `BST_KIND_DATA)
        next_pad_oe[i] = next_sel.extest & next_bs_out[i+1];
    end
  end

  always_ff @(posedge tck_i or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      bs_sh    <= '0;
      bs_out   <= '0;
      pad_oe_o <= '0;
    end
    else
    begin
      bs_sh    <= next_bs_sh;
      bs_out   <= next_bs_out;
      pad_oe_o <= next_pad_oe;
    end
  end

  assign bsc_out_o = bs_out;

  // ****************************************
  // Id and bypass registers
  // ****************************************
  always_comb
  begin
    next_id_sh = id_sh;
    next_byp   = byp;
    if (state == BST_CAP_DR)
    begin
      next_id_sh = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
      next_byp   = 1'b0;
    end
    else if (state == BST_SHIFT_DR)
    begin
      if (sel.idcode)
        next_id_sh = {tdi_i, id_sh[`BST_ID_W-1:1]};
      if (sel.bypass | sel.float_all_outputs_instr)
        next_byp = tdi_i;
    end
  end

  always_ff @(posedge tck_i or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      id_sh <= '0;
      byp   <= 1'b0;
    end
    else
    begin
      id_sh <= next_id_sh;
      byp   <= next_byp;
    end
  end

  // ****************************************
  // Serial output, falling edge
  // ****************************************
  always_comb
  begin
    next_tdo    = 1'b0;
    next_tdo_oe = 1'b0;
    if (state == BST_SHIFT_IR)
    begin
      next_tdo    = ir_sh[0];
      next_tdo_oe = 1'b1;
    end
    else if (state == BST_SHIFT_DR)
    begin
      next_tdo_oe = 1'b1;
      if (bsr_path)
        next_tdo = bs_sh[0];
      else if (sel.idcode)
        next_tdo = id_sh[0];
      else
        next_tdo = byp;
    end
  end

  always_ff @(negedge tck_i or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else
    begin
      tdo_o    <= next_tdo;
      tdo_oe_o <= next_tdo_oe;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge tck_i); endclocking
  default disable iff (!tap_rst_n);

  a_ir_capture_val: assert property (state == BST_CAP_IR |=> ir_sh == 5'h01)
    else $error("capture-IR value wrong");
  a_ir_shift_dir: assert property (state == BST_SHIFT_IR |=>
    ir_sh == {$past(tdi_i), $past(ir_sh[4:1])})
    else $error("IR shift wrong");
  a_ir_out_hold: assert property (state != BST_UPD_IR && state != BST_RESET
    && !prst_s2 |=> $stable(ir_out))
    else $error("IR output changed outside update");
  a_ir_update_copy: assert property (state == BST_UPD_IR |=> ir_out == $past(ir_sh))
    else $error("IR update wrong");
  a_ir_reset_id: assert property (state == BST_RESET |=> sel.idcode && ir_out == 5'h02)
    else $error("reset did not select id read");
  a_sel_decode: assert property (sel.bypass == (ir_out > 5'h03)
    && sel.extest == (ir_out == 5'h00))
    else $error("instruction decode wrong");
  a_bs_shift_in: assert property (state == BST_SHIFT_DR && bsr_path |=>
    bs_sh[280] == $past(tdi_i) && bs_sh[279:0] == $past(bs_sh[280:1]))
    else $error("boundary shift wrong");
  a_bs_out_hold: assert property (state != BST_UPD_DR |=> $stable(bs_out))
    else $error("boundary output changed outside update");
  a_bs_update_copy: assert property (state == BST_UPD_DR && bsr_path |=>
    bs_out == $past(bs_sh))
    else $error("boundary update wrong");
  a_bs_rsvd_zero: assert property (state == BST_CAP_DR && bsr_path |=> !bs_sh[0])
    else $error("reserved bit captured nonzero");
  a_id_lsb_one: assert property (state == BST_CAP_DR |=> id_sh[0])
    else $error("id LSB not one");
  a_float_no_drive: assert property (sel.float_all_outputs_instr |-> pad_oe_o == '0)
    else $error("pad driven while floating");

endmodule
`default_nettype wire

// ==== bstap_host_model.sv ====
// Test controller model driving the scan port pins
`timescale 1ns/100ps
`default_nettype none
module bstap_host_model (
  // Scan port pins
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  input  wire logic tdo_i
);
  initial
  begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h1;
  end

  // One test clock; tdo taken just before the rising edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #40;
    tdo = tdo_i;
    tck_o = 1'h1;
    #40;
    tck_o = 1'h0;
  endtask

  // Walk n states, tms taken LSB first, tdi idles high
  task automatic walk(input logic [7:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++)
      step(seq[i], 1'h1, d);
  endtask

  task automatic tap_reset();
    walk(8'h1F, 6);
  endtask

  // From idle: capture, shift n bits, stop in exit1
  task automatic shift(input logic ir, input logic [280:0] din, input int n,
                       output logic [280:0] dout);
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int k = 0; k < n; k++)
      step(k == n - 1, din[k], dout[k]);
  endtask

  // Exit1 to update, then idle
  task automatic finish();
    walk(8'h01, 2);
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the boundary-scan port registers
`timescale 1ns/100ps
`default_nettype none
`include "bstap_regs.svh"
module tb_top;
  import bstap_pkg::*;
  localparam logic [31:0] ID_EXP = {4'h3, 16'h1234, 11'h2AB, 1'h1};
  localparam logic [`BST_BSR_MSB:0] X = {{140{2'h1}}, 1'h1};
  localparam logic [`BST_BSR_MSB:0] P = ~X;
  localparam logic [`BST_BSR_MSB:0] Y = {{93{3'h6}}, 2'h1};
  logic mclk, resetn, proc_reset, trst_n, tck, tms, tdi, tdo, tdo_oe, iso;
  logic [`BST_BSR_MSB:0] core_oe, pad, bsc_out, pad_oe, got, keep;
  bstap_sel_s sel;
  int error_cnt = 0;
  int n_compared = 0;

  // ****************
  // Design and model
  // ****************
  bstap_top #(.ID_VERSION(4'h3), .ID_PART(16'h1234), .ID_MAKER(11'h2AB)) dut (
    .mclk_i(mclk), .resetn_i(resetn), .proc_reset_i(proc_reset),
    .core_oe_i(core_oe), .core_isolate_o(iso), .tck_i(tck), .trst_n_i(trst_n),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_i(pad),
    .bsc_out_o(bsc_out), .pad_oe_o(pad_oe), .sel_o(sel));
  bstap_host_model host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

  initial
  begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [`BST_BSR_MSB:0] g, input logic [`BST_BSR_MSB:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic bstap_sel_s mk(input logic [4:0] op);
    mk = '0;
    case (op)
      5'h00: mk.extest = 1'h1;
      5'h01: mk.sample = 1'h1;
      5'h02: mk.idcode = 1'h1;
      5'h03: mk.float_all_outputs_instr = 1'h1;
      default: mk.bypass = 1'h1;
    endcase
  endfunction

  task automatic core(input logic pr, input logic [`BST_BSR_MSB:0] oe, pd);
    @(posedge mclk);
    #1;
    proc_reset = pr;
    core_oe = oe;
    pad = pd;
  endtask

  task automatic set_ir(input logic [4:0] op);
    host.shift(1'h1, {276'h0, op}, 5, got);
    host.finish();
    chk(got[4:0], 5'h01);
    chk(sel, mk(op));
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic test_id();
    host.tap_reset();
    chk(sel, mk(5'h02));
    host.shift(1'h0, '0, 32, got);
    host.finish();
    chk(got[31:0], ID_EXP);
    $display("test_id done");
  endtask

  task automatic test_decode();
    logic [4:0] ops [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1E, 5'h1F};
    foreach (ops[i])
      set_ir(ops[i]);
    host.shift(1'h0, 281'h2, 3, got);
    host.finish();
    chk(got[2:0], 3'h4);
    host.walk(8'h1B, 6);
    chk(sel, mk(5'h01));
    $display("test_decode done");
  endtask

  task automatic test_sample();
    core(1'h0, X, X);
    set_ir(5'h01);
    keep = bsc_out;
    host.shift(1'h0, P, 281, got);
    chk(bsc_out, keep);
    host.finish();
    chk(got, X & ~281'h1);
    chk(bsc_out, P);
    chk(pad_oe, '0);
    $display("test_sample done");
  endtask

  task automatic test_extest();
    core(1'h0, '0, Y);
    set_ir(5'h00);
    repeat (4) @(posedge mclk);
    chk(iso, 1'h1);
    chk(pad_oe[280:279], 2'h1);
    keep = bsc_out;
    host.shift(1'h0, X, 281, got);
    chk(bsc_out, keep);
    host.finish();
    chk(got[280], P[280]);
    chk(got[279], Y[279]);
    chk(got[210], Y[210]);
    chk(got[0], 1'h0);
    chk(bsc_out, X);
    chk(pad_oe[279], X[280]);
    $display("test_extest done");
  endtask

  task automatic test_float_reset();
    set_ir(5'h03);
    repeat (4) @(posedge mclk);
    chk(pad_oe, '0);
    chk(iso, 1'h1);
    set_ir(5'h01);
    core(1'h1, X, Y);
    repeat (2) @(posedge mclk);
    host.walk(8'h00, 4);
    chk(sel, mk(5'h02));
    core(1'h0, X, Y);
    host.tap_reset();
    set_ir(5'h01);
    @(posedge mclk);
    #1;
    trst_n = 1'h0;
    #10;
    chk(sel, mk(5'h02));
    trst_n = 1'h1;
    $display("test_float_reset done");
  endtask

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    resetn = 1'h0;
    trst_n = 1'h0;
    proc_reset = 1'h0;
    core_oe = '0;
    pad = '0;
    repeat (5) @(posedge mclk);
    host.walk(8'hFF, 2);
    @(posedge mclk);
    #1;
    resetn = 1'h1;
    trst_n = 1'h1;
    chk(sel, mk(5'h02));
    chk(iso, 1'h0);
    chk(tdo_oe, 1'h0);
    chk(pad_oe, '0);
    test_id();
    test_decode();
    test_sample();
    test_extest();
    test_float_reset();
    print_verdict();
  end

  initial
  begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
